/* scp_pkg.sv */
// package of constants and types for the serial com port block
package scp_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TXDATA = 8'h08;
	localparam logic [7:0] REG_RXDATA = 8'h0c;
	localparam logic [7:0] REG_IDENT  = 8'h10;
	// ctrl field positions
	localparam int CTRL_RATE_LSB  = 0;
	localparam int CTRL_FRAME_LSB = 4;
	localparam int CTRL_IFACE_LSB = 6;
	localparam int CTRL_EOL_BIT   = 8;
	localparam int CTRL_PRE_LSB   = 9;
	// protocol codes, fixed at manufacture
	typedef enum logic [1:0] {
		SCP_PROTO_ASCII  = 2'h0,
		SCP_PROTO_MODBUS = 2'h1,
		SCP_PROTO_HART   = 2'h2,
		SCP_PROTO_NONE   = 2'h3
	} scp_proto_t;
	typedef enum logic [1:0] {
		SCP_IF_RS232 = 2'h0,
		SCP_IF_RS485 = 2'h1,
		SCP_IF_FSK   = 2'h2
	} scp_iface_t;
	typedef enum logic [1:0] {
		SCP_FR_N81 = 2'h0,
		SCP_FR_N82 = 2'h1,
		SCP_FR_E81 = 2'h2,
		SCP_FR_O81 = 2'h3
	} scp_frame_t;
	// rate index table
	localparam logic [3:0] RATE_1200 = 4'h2;
	localparam logic [3:0] RATE_9600 = 4'h5;
	localparam int         RATE_NUM  = 14;
	localparam int         CLK_HZ    = 200000000;
	// oversample ticks per bit
	localparam int         OVS       = 16;
	// special characters
	localparam logic [7:0] CH_XOFF   = 8'h13;
	localparam logic [7:0] CH_XON    = 8'h11;
	localparam logic [7:0] CH_CR     = 8'h0d;
	localparam logic [7:0] CH_LF     = 8'h0a;
	localparam logic [7:0] CH_PRE    = 8'hff;
	localparam logic [4:0] PRE_MIN   = 5'h03;
	localparam logic [4:0] PRE_MAX   = 5'h14;
	localparam logic [4:0] PRE_DEF   = 5'h05;
	// arbitrary identity value
	localparam logic [15:0] IDENT_VAL = 16'h5a3c;
	// divisor per rate index, for 16x oversampling
	function automatic logic [15:0] rate_div(input logic [3:0] idx);
		int baud;
		case (idx)
			4'h0: baud = 300;
			4'h1: baud = 600;
			4'h2: baud = 1200;
			4'h3: baud = 2400;
			4'h4: baud = 4800;
			4'h5: baud = 9600;
			4'h6: baud = 14400;
			4'h7: baud = 19200;
			4'h8: baud = 28800;
			4'h9: baud = 38400;
			4'ha: baud = 57600;
			4'hb: baud = 115200;
			4'hc: baud = 230400;
			default: baud = 460800;
		endcase
		return 16'(CLK_HZ / (baud * OVS));
	endfunction : rate_div
endpackage : scp_pkg

/* scp_fifo_if.sv */
// valid/ready carrier between the port and its transmit buffer
`timescale 1ns/1ps
interface scp_fifo_if;
	logic       valid;
	logic       ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : scp_fifo_if

/* scp_buf2.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module scp_buf2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// filling and draining sides
	scp_fifo_if.snk   in_s,
	scp_fifo_if.src   out_s
);
	logic [W-1:0] mem [2];
	logic         wp;
	logic         rp;
	logic [1:0]   cnt;
	wire          push = in_s.valid && in_s.ready;
	wire          pop  = out_s.valid && out_s.ready;

	// full and empty flags
	assign in_s.ready  = (cnt != 2'h2);
	assign out_s.valid = (cnt != 2'h0);
	assign out_s.data  = mem[rp];

	// pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp  <= 1'b0;
			rp  <= 1'b0;
			cnt <= 2'h0;
		end else begin
			if (push) wp <= ~wp;
			if (pop) rp <= ~rp;
			cnt <= 2'(cnt + {1'b0, push} - {1'b0, pop});
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (push) mem[wp] <= in_s.data;
	end
endmodule : scp_buf2

/* scp_port.sv */
// configurable serial com port with apb registers
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
// Behaviour
// - protocol is ASCII, Modbus, HART or None; fixed at build, default ASCII
// - RS232/RS485 only under ASCII or Modbus; FSK only under HART (under None the port still runs RS232)
// - fourteen rates from 300 to 460.8k baud
// - HART forces 1200 baud; others reset to 9600
// - 8 data bits; frames N81, N82, E81, O81
// - HART locks O81; others default N81
// - settings writable under ASCII/Modbus; under HART only the preamble count is writable
// - XOFF (19) pauses stream; XON (17) resumes it
// - RS485 is half duplex: no receive while transmitting
// - end of line sends CR or CR then LF per setting
// - HART reply begins with 3..20 FF preamble bytes, default 5
module scp_port #(
	parameter scp_pkg::scp_proto_t PROTO = scp_pkg::SCP_PROTO_ASCII
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial line
	input  wire logic        rxd,
	output logic             txd,
	output logic             tx_drive,
	output logic             fsk_sel
);
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_PAR   = 5'b01000,
		TX_STOP  = 5'b10000
	} scp_txst_t;

	localparam bit HART = (PROTO == scp_pkg::SCP_PROTO_HART);
	localparam bit USER = (PROTO == scp_pkg::SCP_PROTO_ASCII) ||
		(PROTO == scp_pkg::SCP_PROTO_MODBUS);

	logic [3:0]  rate;
	logic [1:0]  frame;
	logic [1:0]  iface;
	logic        eol_lf;
	logic [4:0]  pre_num;
	logic        paused;
	logic [7:0]  rx_byte;
	logic        rx_full;
	logic [15:0] div_cnt;
	logic        tick;
	scp_fifo_if  wr_if ();
	scp_fifo_if  tx_if ();

	wire         acc    = psel && penable;
	wire         wr_acc = acc && pwrite;
	wire [15:0]  div_v  = scp_pkg::rate_div(HART ? scp_pkg::RATE_1200 : rate);
	wire         tx_busy;
	wire         rx_byte_stb;
	wire         eol_req = wr_acc && (paddr == scp_pkg::REG_TXDATA) && pwdata[8];

	// settings, writable only under ASCII or Modbus; preamble count writable only under HART
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rate    <= scp_pkg::RATE_9600;
			frame   <= scp_pkg::SCP_FR_N81;
			iface   <= scp_pkg::SCP_IF_RS232;
			eol_lf  <= 1'b0;
			pre_num <= scp_pkg::PRE_DEF;
		end else if (wr_acc && paddr == scp_pkg::REG_CTRL) begin
			if (USER) begin
				if (pwdata[scp_pkg::CTRL_RATE_LSB+:4] < 4'(scp_pkg::RATE_NUM))
					rate <= pwdata[scp_pkg::CTRL_RATE_LSB+:4];
				frame  <= pwdata[scp_pkg::CTRL_FRAME_LSB+:2];
				if (pwdata[scp_pkg::CTRL_IFACE_LSB+:2] != scp_pkg::SCP_IF_FSK)
					iface <= pwdata[scp_pkg::CTRL_IFACE_LSB+:2];
				eol_lf <= pwdata[scp_pkg::CTRL_EOL_BIT];
			end
			if (HART && pwdata[scp_pkg::CTRL_PRE_LSB+:5] >= scp_pkg::PRE_MIN &&
				pwdata[scp_pkg::CTRL_PRE_LSB+:5] <= scp_pkg::PRE_MAX)
				pre_num <= pwdata[scp_pkg::CTRL_PRE_LSB+:5];
		end
	end

	// effective settings; hart locks frame and interface
	wire [1:0] eff_frame = HART ? scp_pkg::SCP_FR_O81 : frame;
	wire [1:0] eff_iface = HART ? scp_pkg::SCP_IF_FSK : iface;

	// 16x oversample enable divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b0;
		end else if (div_cnt >= div_v - 16'h0001) begin
			div_cnt <= 16'h0000;
			tick    <= 1'b1;
		end else begin
			div_cnt <= 16'(div_cnt + 16'h0001);
			tick    <= 1'b0;
		end
	end

	// write sequencer: preamble, data, end-of-line characters
	logic [4:0] pre_left;
	logic [1:0] eol_left;
	logic [7:0] hold;
	logic       hold_v;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_left <= 5'h00;
			eol_left <= 2'h0;
			hold     <= 8'h00;
			hold_v   <= 1'b0;
		end else if (!hold_v && eol_left == 2'h0 &&
			wr_acc && paddr == scp_pkg::REG_TXDATA) begin
			hold     <= pwdata[7:0];
			hold_v   <= !eol_req || pwdata[9];
			pre_left <= (HART && pwdata[10]) ? pre_num : 5'h00;
			eol_left <= eol_req ? (eol_lf ? 2'h2 : 2'h1) : 2'h0;
		end else if (wr_if.ready && !paused) begin
			if (pre_left != 5'h00) pre_left <= 5'(pre_left - 5'h01);
			else if (hold_v) hold_v <= 1'b0;
			else if (eol_left != 2'h0) eol_left <= 2'(eol_left - 2'h1);
		end
	end
	assign wr_if.valid = !paused && (pre_left != 5'h00 || hold_v || eol_left != 2'h0);
	assign wr_if.data  = (pre_left != 5'h00) ? scp_pkg::CH_PRE :
		hold_v ? hold :
		(eol_left == 2'h2) ? scp_pkg::CH_CR :
		(eol_lf ? scp_pkg::CH_LF : scp_pkg::CH_CR);

	scp_buf2 #(.W(8)) u_buf (
		.clk   (clk),
		.rst_n (rst_n),
		.in_s  (wr_if),
		.out_s (tx_if)
	);

	// transmitter
	scp_txst_t  tst;
	logic [3:0] tph;
	logic [2:0] tbit;
	logic [7:0] tsh;
	logic       tpar;
	logic       tstop2;
	assign tx_if.ready = (tst == TX_IDLE);
	assign tx_busy     = (tst != TX_IDLE);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tst    <= TX_IDLE;
			tph    <= 4'h0;
			tbit   <= 3'h0;
			tsh    <= 8'h00;
			tpar   <= 1'b0;
			tstop2 <= 1'b0;
			txd    <= 1'b1;
		end else begin
			case (tst)
				TX_IDLE: begin
					txd <= 1'b1;
					if (tx_if.valid) begin
						tsh    <= tx_if.data;
						tpar   <= (^tx_if.data) ^ (eff_frame == scp_pkg::SCP_FR_O81);
						tstop2 <= (eff_frame == scp_pkg::SCP_FR_N82);
						tph    <= 4'h0;
						tbit   <= 3'h0;
						tst    <= TX_START;
					end
				end
				TX_START: begin
					txd <= 1'b0;
					if (tick) begin
						tph <= 4'(tph + 4'h1);
						if (tph == 4'hf) tst <= TX_DATA;
					end
				end
				TX_DATA: begin
					txd <= tsh[0];
					if (tick) begin
						tph <= 4'(tph + 4'h1);
						if (tph == 4'hf) begin
							tsh  <= {1'b0, tsh[7:1]};
							tbit <= 3'(tbit + 3'h1);
							if (tbit == 3'h7)
								tst <= eff_frame[1] ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: begin
					txd <= tpar;
					if (tick) begin
						tph <= 4'(tph + 4'h1);
						if (tph == 4'hf) tst <= TX_STOP;
					end
				end
				TX_STOP: begin
					txd <= 1'b1;
					if (tick) begin
						tph <= 4'(tph + 4'h1);
						if (tph == 4'hf) begin
							if (tstop2) tstop2 <= 1'b0;
							else tst <= TX_IDLE;
						end
					end
				end
				default: tst <= TX_IDLE;
			endcase
		end
	end

	// receiver; rs485 ignores the line while transmitting
	logic [3:0] rph;
	logic [3:0] rbit;
	logic [7:0] rsh;
	logic       ract;
	logic       rstb;
	wire        rx_gate = !(eff_iface == scp_pkg::SCP_IF_RS485 && tx_busy);
	// frame positions: 0 start, 1 to 8 data, then parity if any, then stop
	wire [3:0]  rlast   = eff_frame[1] ? 4'ha : 4'h9;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rph  <= 4'h0;
			rbit <= 4'h0;
			rsh  <= 8'h00;
			ract <= 1'b0;
			rstb <= 1'b0;
		end else begin
			rstb <= 1'b0;
			if (!ract) begin
				if (tick && rx_gate && !rxd) begin
					ract <= 1'b1;
					rph  <= 4'h1;
					rbit <= 4'h0;
				end
			end else if (tick) begin
				rph <= 4'(rph + 4'h1);
				if (rph == 4'h7) begin
					// a start that is high again at mid-bit was a glitch: drop it
					if (rbit == 4'h0 && rxd) ract <= 1'b0;
					else if (rbit == rlast) begin
						ract <= 1'b0;
						rstb <= rxd && rx_gate;
					end else if (rbit != 4'h0 && rbit <= 4'h8)
						rsh <= {rxd, rsh[7:1]};
					rbit <= 4'(rbit + 4'h1);
				end
			end
		end
	end
	assign rx_byte_stb = rstb;

	// flow control and receive holding
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			paused  <= 1'b0;
			rx_byte <= 8'h00;
			rx_full <= 1'b0;
		end else begin
			if (rx_byte_stb && rsh == scp_pkg::CH_XOFF) paused <= 1'b1;
			else if (rx_byte_stb && rsh == scp_pkg::CH_XON) paused <= 1'b0;
			if (rx_byte_stb) begin
				rx_byte <= rsh;
				rx_full <= 1'b1;
			end else if (acc && !pwrite && paddr == scp_pkg::REG_RXDATA)
				rx_full <= 1'b0;
		end
	end

	// apb answers in the access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata   <= 32'h00000000;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			tx_drive <= 1'b0;
			fsk_sel  <= 1'b0;
		end else begin
			tx_drive <= tx_busy;
			fsk_sel  <= (eff_iface == scp_pkg::SCP_IF_FSK);
			pready   <= psel && !penable;
			pslverr  <= 1'b0;
			prdata   <= 32'h00000000;
			if (psel && !penable) begin
				case (paddr)
					scp_pkg::REG_CTRL: prdata <= 32'({pre_num, eol_lf, eff_iface,
						eff_frame, HART ? scp_pkg::RATE_1200 : rate});
					scp_pkg::REG_STATUS: prdata <= 32'({PROTO, paused, rx_full,
						wr_if.ready, tx_busy});
					scp_pkg::REG_TXDATA: prdata <= 32'h00000000;
					scp_pkg::REG_RXDATA: prdata <= 32'({rx_byte});
					scp_pkg::REG_IDENT:  prdata <= 32'(scp_pkg::IDENT_VAL);
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule : scp_port

/* scp_port_chk_properties.sv */
// assertions on the serial com port pins
`timescale 1ns/1ps
module scp_port_chk #(
	parameter scp_pkg::scp_proto_t PROTO = scp_pkg::SCP_PROTO_ASCII
) (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	// serial line
	input wire logic       txd,
	input wire logic       tx_drive,
	input wire logic       fsk_sel
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// apb phases
	sequence s_setup; psel && !penable; endsequence
	sequence s_done; psel && penable && pready; endsequence
	// bus answers and the line's framing
	property p_answer; s_setup |=> s_done; endproperty
	property p_pulse; pready |=> !pready; endproperty
	property p_access; pready |-> psel && penable; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_map; s_done and (paddr > 8'h10) |-> pslverr; endproperty
	property p_idle; !tx_drive |-> txd; endproperty
	property p_start; $fell(txd) |-> tx_drive; endproperty
	property p_startlen; $fell(txd) |-> (!txd)[*8]; endproperty
	property p_fsk; $past(rst_n) |-> fsk_sel == (PROTO == scp_pkg::SCP_PROTO_HART); endproperty
	a_answer: assert property (p_answer) else $error("setup not answered");
	a_pulse: assert property (p_pulse) else $error("pready too long");
	a_access: assert property (p_access) else $error("pready outside access");
	a_err: assert property (p_err) else $error("pslverr without pready");
	a_map: assert property (p_map) else $error("unmapped not refused");
	a_idle: assert property (p_idle) else $error("line not idle high");
	a_start: assert property (p_start) else $error("start while not driving");
	a_startlen: assert property (p_startlen) else $error("start bit short");
	a_fsk: assert property (p_fsk) else $error("fsk select wrong");
endmodule : scp_port_chk
bind scp_port scp_port_chk #(.PROTO(PROTO)) i_chk (.clk, .rst_n, .psel, .penable,
	.paddr, .pready, .pslverr, .txd, .tx_drive, .fsk_sel);

/* scp_host.sv */
// host-side serial partner: sends and captures characters
`timescale 1ns/1ps
module scp_host #(
	parameter int BIT = 432
) (
	// clock
	input wire logic clk,
	// serial line
	input wire logic txd,
	output logic     rxd
);
	int          nbits = 9;
	logic [11:0] q[$];
	initial rxd = 1'b1;
	// capture bits after start at mid-bit, stops included
	always begin
		logic [11:0] w;
		@(negedge txd);
		w = 12'h000;
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			repeat (BIT) @(posedge clk);
			w[i] = txd;
		end
		q.push_back(w);
	end
	// send one n81 character, idle high after
	task send(input logic [7:0] b);
		rxd <= 1'b0;
		repeat (BIT) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			rxd <= b[i];
			repeat (BIT) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (BIT) @(posedge clk);
	endtask : send
endmodule : scp_host

/* scp_port_tb.sv */
// self-checking bench for the serial com port
`timescale 1ns/1ps
module scp_port_tb;
	localparam int BIT = scp_pkg::CLK_HZ / (460800 * scp_pkg::OVS) * scp_pkg::OVS;
	logic        clk = 0;
	logic        rst_n = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        tx_drive;
	logic        fsk_sel;
	logic [31:0] rd;
	logic        re;
	int          err_total = 0;
	int          n_compared = 0;
	always #2.5 clk = ~clk;
	scp_port i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .rxd, .txd, .tx_drive, .fsk_sel);
	scp_host #(.BIT(BIT)) i_host (.clk, .txd, .rxd);
	// compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task final_report;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	// one apb transfer, waits for pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// expected captured word for byte and frame
	function automatic logic [11:0] frm(input logic [7:0] b, input logic [1:0] f);
		case (f)
			2'h0: return {3'h0, 1'b1, b};
			2'h1: return {2'h0, 2'h3, b};
			2'h2: return {2'h0, 1'b1, ^b, b};
			default: return {2'h0, 1'b1, ~^b, b};
		endcase
	endfunction : frm
	// wait for a character, then for the line to settle
	task rxw(input logic [11:0] e);
		int          n;
		logic [11:0] w;
		n = 0;
		w = 12'hxxx;
		while (i_host.q.size() == 0 && n < 20 * BIT) begin
			@(posedge clk);
			n++;
		end
		if (i_host.q.size() != 0) w = i_host.q.pop_front();
		chk("char", 32'(e), 32'(w));
		n = 0;
		while (tx_drive !== 1'b0 && n < 4 * BIT) begin
			@(posedge clk);
			n++;
		end
		chk("settle", 32'h0, 32'(tx_drive));
		@(posedge clk);
	endtask : rxw
	// defaults, protocol, unmapped access
	task t_reset;
		apb(1'b0, scp_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h00000a05, rd);
		apb(1'b0, scp_pkg::REG_STATUS, 32'h0);
		chk("proto", 32'h0, 32'(rd[5:4]));
		apb(1'b0, 8'h14, 32'h0);
		chk("slverr", 32'h1, 32'(re));
	endtask : t_reset
	// settings writable, bad rate and fsk refused, rs485 taken
	task t_cfg;
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a2d);
		apb(1'b0, scp_pkg::REG_CTRL, 32'h0);
		chk("ctrl", 32'h00000a2d, rd);
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a2e);
		apb(1'b0, scp_pkg::REG_CTRL, 32'h0);
		chk("rate", 32'hd, 32'(rd[3:0]));
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000aad);
		apb(1'b0, scp_pkg::REG_CTRL, 32'h0);
		chk("iface", 32'h0, 32'(rd[7:6]));
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a6d);
		apb(1'b0, scp_pkg::REG_CTRL, 32'h0);
		chk("rs485", 32'h1, 32'(rd[7:6]));
	endtask : t_cfg
	// every frame format on the wire
	task t_frames;
		for (int f = 0; f < 4; f++) begin
			i_host.nbits = (f == 0) ? 9 : 10;
			apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a0d | (f << 4));
			apb(1'b1, scp_pkg::REG_TXDATA, 32'(8'hb4 ^ f));
			rxw(frm(8'hb4 ^ f, 2'(f)));
		end
		i_host.nbits = 9;
	endtask : t_frames
	// end of line with and without line feed
	task t_eol;
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000b0d);
		apb(1'b1, scp_pkg::REG_TXDATA, 32'h00000341);
		rxw(frm(8'h41, 2'h0));
		rxw(frm(scp_pkg::CH_CR, 2'h0));
		rxw(frm(scp_pkg::CH_LF, 2'h0));
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a0d);
		apb(1'b1, scp_pkg::REG_TXDATA, 32'h00000100);
		rxw(frm(scp_pkg::CH_CR, 2'h0));
		repeat (12 * BIT) @(posedge clk);
		chk("extra", 32'h0, 32'(i_host.q.size()));
	endtask : t_eol
	// flow off holds a character until flow on
	task t_flow;
		i_host.send(scp_pkg::CH_XOFF);
		apb(1'b0, scp_pkg::REG_STATUS, 32'h0);
		chk("paused", 32'h1, 32'(rd[3]));
		apb(1'b1, scp_pkg::REG_TXDATA, 32'h00000055);
		repeat (15 * BIT) @(posedge clk);
		chk("held", 32'h0, 32'(i_host.q.size()));
		i_host.send(scp_pkg::CH_XON);
		rxw(frm(8'h55, 2'h0));
		apb(1'b0, scp_pkg::REG_RXDATA, 32'h0);
		chk("rxdata", 32'(scp_pkg::CH_XON), rd);
	endtask : t_flow
	// rs485 is deaf to flow off while it sends
	task t_half;
		apb(1'b1, scp_pkg::REG_CTRL, 32'h00000a4d);
		apb(1'b1, scp_pkg::REG_TXDATA, 32'h00000041);
		repeat (BIT / 2) @(posedge clk);
		i_host.send(scp_pkg::CH_XOFF);
		apb(1'b0, scp_pkg::REG_STATUS, 32'h0);
		chk("deaf", 32'h0, 32'(rd[3]));
		rxw(frm(8'h41, 2'h0));
	endtask : t_half
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset;
		t_cfg;
		t_frames;
		t_eol;
		t_flow;
		t_half;
		final_report;
	end
	// watchdog against a hang, about two fifths above the expected run
	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		final_report;
	end
endmodule : scp_port_tb
